/* hw/efts_defs.svh */
// Purpose: constants of the event flag, tick and core clock block
// Assumes: byte-wide register port, 10 MHz mclk
// Notes: multi-byte registers are big-endian, lowest address holds the top byte
//
// Overview of operation
// - interrupt enable low keeps irq pin high
// - interrupt enable high: pending event drives pin low
// - clock select bit, writable only when unlocked
// - 16-bit tick counter counts every 100 us
// - any write to tick clear zeroes counter
// - magic packet sets global flag bit 7
// - ipv6 unreachable sets bit 4, stores port, stores address unless a prefix latches in the same cycle
// - ipv4 address conflict sets global bit 2
// - ipv4 unreachable sets bit 1, stores address, port
// - pppoe termination sets global flag bit 0
// - summary bit n is socket n flags nonzero
// - socketless command timeout sets bit 7
// - arp reply after request sets bit 6
// - ipv4 echo reply after ping sets bit 5
// - ipv6 neighbor reply after resolve sets bit 4
// - ipv6 echo reply after ping sets bit 3
// - advertisement after duplicate check sets bit 2
// - advertisement after solicitation sets bit 1
// - unsolicited gateway advertisement sets bit 0
// - advertisement flag bit 1 or 0 set latches prefix registers, bit 2 does not
// - prefix valid only with option order 1, 3
// - writing one clears global flag, zero keeps
// - writing one clears socketless flag
// - mask bit one lets global flag interrupt
`ifndef EFTS_DEFS_SVH
`define EFTS_DEFS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define EFTS_SYSCFG1_ADDR 16'h2005
`define EFTS_TICK_ADDR 16'h2016
`define EFTS_TICK_CLR_ADDR 16'h2020
`define EFTS_GFLAG_ADDR 16'h2100
`define EFTS_SUMMARY_ADDR 16'h2101
`define EFTS_SLFLAG_ADDR 16'h2102
`define EFTS_GMASK_ADDR 16'h2104
`define EFTS_GCLR_ADDR 16'h2108
`define EFTS_SMASK_ADDR 16'h2114
`define EFTS_SLMASK_ADDR 16'h2124
`define EFTS_SLCLR_ADDR 16'h2128
`define EFTS_IPV6_PORT_UNREACHABLE_FLAG_ADDR_BASE 16'h2030
`define EFTS_IPV6_PORT_UNREACHABLE_FLAG_PORT_BASE 16'h2040
`define EFTS_IPV4_PORT_UNREACHABLE_FLAG_ADDR_BASE 16'h2044
`define EFTS_IPV4_PORT_UNREACHABLE_FLAG_PORT_BASE 16'h2048
`define EFTS_PLEN_ADDR 16'h2050
`define EFTS_PFLAG_ADDR 16'h2051
`define EFTS_PVALID_ADDR 16'h2052
`define EFTS_VLIFE_BASE 16'h2054
`define EFTS_PLIFE_BASE 16'h2058
`define EFTS_PADDR_BASE 16'h2060
`define EFTS_MASK16 16'hfff0
`define EFTS_MASK4 16'hfffc
`define EFTS_MASK2 16'hfffe

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define EFTS_IEN_BIT 7
`define EFTS_CORE_CLOCK_SELECT_BIT 0
`define EFTS_SYSCFG1_RST 8'h80
`define EFTS_GFLAG_USED 8'h97
`define EFTS_GF_WOL 7
`define EFTS_GF_IPV6_PORT_UNREACHABLE_FLAG 4
`define EFTS_GF_IPV4_CONFLICT_FLAG 2
`define EFTS_GF_IPV4_PORT_UNREACHABLE_FLAG 1
`define EFTS_GF_PPPOE_TERMINATED_FLAG 0
`define EFTS_SL_RS 1
`define EFTS_SL_RA 0
`define EFTS_ZERO8 8'h00
`define EFTS_ZERO16 16'h0000
`define EFTS_MEM_PADDR 1'b0
`define EFTS_MEM_IPV6_PORT_UNREACHABLE_FLAG 1'b1

// ----------------------------------------
// timing
// ----------------------------------------
`define EFTS_CLK_PERIOD_NS 100
`define EFTS_TICK_PERIOD_US 100
`define EFTS_TICK_CYCLES ((`EFTS_TICK_PERIOD_US * 1000) / `EFTS_CLK_PERIOD_NS)
`define EFTS_PRE_W 10

`endif

/* hw/efts_pkg.sv */
// Purpose: shared types of the event flag, tick and core clock block
// Assumes: nothing beyond the defs header
// Notes: constants live in efts_defs.svh
package efts_pkg;
  typedef logic [7:0] efts_byte_t;
  typedef logic [15:0] efts_addr_t;
  typedef logic [127:0] efts_wide_t;
endpackage

/* hw/efts_wide_mem.sv */
// Purpose: two-entry store for the 128-bit latched addresses
// Assumes: single clock, one write and one read port
// Notes: read data is registered, one cycle after raddr
`timescale 1ns/1ns
module efts_wide_mem
  import efts_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic we,
  input wire logic waddr,
  input wire efts_wide_t wdata,
  input wire logic raddr,
  output efts_wide_t rdata_q
);
  efts_wide_t mem_q [2];

  // ----------------------------------------
  // storage
  // ----------------------------------------
  // entries clear at reset so unlatched values read as zero
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      rdata_q <= '0;
    end else begin
      if (we) begin
        mem_q[waddr] <= wdata;
      end
      rdata_q <= mem_q[raddr];
    end
  end
endmodule

/* hw/efts_event_block.sv */
// Purpose: host-visible event flags, interrupt pin, tick counter, clock select
// Assumes: register strobes and event pulses come from logic on mclk
// Notes: host reads return two cycles after the read strobe
`timescale 1ns/1ns
`include "efts_defs.svh"
module efts_event_block
  import efts_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire efts_addr_t host_addr,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire efts_byte_t host_wdata,
  output efts_byte_t host_rdata,
  output logic host_rvalid,
  input wire logic chip_config_lock,
  input wire logic evt_wol,
  input wire logic evt_ipv6_unreach,
  input wire efts_wide_t unreach6_addr,
  input wire logic [15:0] unreach6_port,
  input wire logic evt_ipv4_conflict,
  input wire logic evt_ipv4_unreach,
  input wire logic [31:0] unreach4_addr,
  input wire logic [15:0] unreach4_port,
  input wire logic evt_pppoe_term,
  input wire logic [63:0] socket_n_flags,
  input wire efts_byte_t socketless_events,
  input wire efts_byte_t ra_prefix_length,
  input wire efts_byte_t ra_prefix_flags,
  input wire logic [31:0] ra_valid_lifetime,
  input wire logic [31:0] ra_preferred_lifetime,
  input wire efts_wide_t ra_prefix_address,
  input wire logic ra_options_ok,
  output logic irq_out_low,
  output logic core_clock_select
);
  localparam int TICK_CYCLES = `EFTS_TICK_CYCLES;
  localparam logic [`EFTS_PRE_W-1:0] PRE_LAST = `EFTS_PRE_W'(TICK_CYCLES - 1);
  localparam efts_byte_t CFG_RST = `EFTS_SYSCFG1_RST;

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  wire wr_cfg = host_wr && (host_addr == `EFTS_SYSCFG1_ADDR);
  wire wr_tclr = host_wr && (host_addr == `EFTS_TICK_CLR_ADDR);
  wire wr_gmask = host_wr && (host_addr == `EFTS_GMASK_ADDR);
  wire wr_gclr = host_wr && (host_addr == `EFTS_GCLR_ADDR);
  wire wr_smask = host_wr && (host_addr == `EFTS_SMASK_ADDR);
  wire wr_slmask = host_wr && (host_addr == `EFTS_SLMASK_ADDR);
  wire wr_slclr = host_wr && (host_addr == `EFTS_SLCLR_ADDR);

  // ----------------------------------------
  // system config 1
  // ----------------------------------------
  logic ien_q;
  logic core_clock_select_q;
  // clock select holds while the chip configuration lock is set
  wire core_clock_select_d = (wr_cfg && !chip_config_lock) ? host_wdata[`EFTS_CORE_CLOCK_SELECT_BIT] : core_clock_select_q;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ien_q <= CFG_RST[`EFTS_IEN_BIT];
      core_clock_select_q <= CFG_RST[`EFTS_CORE_CLOCK_SELECT_BIT];
    end else begin
      if (wr_cfg) begin
        ien_q <= host_wdata[`EFTS_IEN_BIT];
      end
      core_clock_select_q <= core_clock_select_d;
    end
  end
  assign core_clock_select = core_clock_select_q;

  // ----------------------------------------
  // tick counter
  // ----------------------------------------
  logic [`EFTS_PRE_W-1:0] pre_q;
  logic [15:0] tick_q;
  wire tick_en = (pre_q == PRE_LAST);
  // a clear also restarts the prescaler so the first step is a full period
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pre_q <= '0;
      tick_q <= `EFTS_ZERO16;
    end else if (wr_tclr) begin
      pre_q <= '0;
      tick_q <= `EFTS_ZERO16;
    end else begin
      pre_q <= tick_en ? '0 : pre_q + 1'b1;
      if (tick_en) begin
        tick_q <= tick_q + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // global event flags
  // ----------------------------------------
  efts_byte_t gflag_q;
  efts_byte_t gmask_q;
  efts_byte_t gset;
  assign gset[`EFTS_GF_WOL] = evt_wol;
  assign gset[6:5] = 2'b00;
  assign gset[`EFTS_GF_IPV6_PORT_UNREACHABLE_FLAG] = evt_ipv6_unreach;
  assign gset[3] = 1'b0;
  assign gset[`EFTS_GF_IPV4_CONFLICT_FLAG] = evt_ipv4_conflict;
  assign gset[`EFTS_GF_IPV4_PORT_UNREACHABLE_FLAG] = evt_ipv4_unreach;
  assign gset[`EFTS_GF_PPPOE_TERMINATED_FLAG] = evt_pppoe_term;
  // an event in the clearing cycle survives: set wins over clear
  wire [7:0] gclr_bits = wr_gclr ? host_wdata : `EFTS_ZERO8;
  wire [7:0] gflag_d = ((gflag_q & ~gclr_bits) | gset) & `EFTS_GFLAG_USED;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      gflag_q <= `EFTS_ZERO8;
      gmask_q <= `EFTS_ZERO8;
    end else begin
      gflag_q <= gflag_d;
      if (wr_gmask) begin
        gmask_q <= host_wdata & `EFTS_GFLAG_USED;
      end
    end
  end

  // ----------------------------------------
  // socket summary
  // ----------------------------------------
  efts_byte_t summary;
  efts_byte_t summary_q;
  efts_byte_t smask_q;
  for (genvar n = 0; n < 8; n++) begin : g_sock
    assign summary[n] = |socket_n_flags[8*n +: 8];
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      summary_q <= `EFTS_ZERO8;
      smask_q <= `EFTS_ZERO8;
    end else begin
      summary_q <= summary;
      if (wr_smask) begin
        smask_q <= host_wdata;
      end
    end
  end

  // ----------------------------------------
  // socketless event flags
  // ----------------------------------------
  // bit order: timeout, ipv4_resolve_done_flag, ipv4_echo_done_flag, ipv6_resolve_done_flag, ipv6_echo_done_flag, dad, rs, unsolicited ra
  efts_byte_t slflag_q;
  efts_byte_t slmask_q;
  wire [7:0] slclr_bits = wr_slclr ? host_wdata : `EFTS_ZERO8;
  wire [7:0] slflag_d = (slflag_q & ~slclr_bits) | socketless_events;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      slflag_q <= `EFTS_ZERO8;
      slmask_q <= `EFTS_ZERO8;
    end else begin
      slflag_q <= slflag_d;
      if (wr_slmask) begin
        slmask_q <= host_wdata;
      end
    end
  end

  // ----------------------------------------
  // interrupt pin
  // ----------------------------------------
  // registered so the pin never glitches on decode
  wire any_pending = |(gflag_q & gmask_q) | |(summary_q & smask_q) | |(slflag_q & slmask_q);
  wire irq_d = !(ien_q && any_pending);
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irq_out_low <= 1'b1;
    end else begin
      irq_out_low <= irq_d;
    end
  end

  // ----------------------------------------
  // latched unreachable and prefix values
  // ----------------------------------------
  logic [15:0] u6port_q;
  logic [31:0] u4addr_q;
  logic [15:0] u4port_q;
  efts_byte_t plen_q;
  efts_byte_t pflag_q;
  logic pvalid_q;
  logic [31:0] vlife_q;
  logic [31:0] plife_q;
  wire ra_take = socketless_events[`EFTS_SL_RS] || socketless_events[`EFTS_SL_RA];
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      u6port_q <= `EFTS_ZERO16;
      u4addr_q <= '0;
      u4port_q <= `EFTS_ZERO16;
      plen_q <= `EFTS_ZERO8;
      pflag_q <= `EFTS_ZERO8;
      pvalid_q <= 1'b0;
      vlife_q <= '0;
      plife_q <= '0;
    end else begin
      if (evt_ipv6_unreach) begin
        u6port_q <= unreach6_port;
      end
      if (evt_ipv4_unreach) begin
        u4addr_q <= unreach4_addr;
        u4port_q <= unreach4_port;
      end
      if (ra_take) begin
        plen_q <= ra_prefix_length;
        pflag_q <= ra_prefix_flags;
        vlife_q <= ra_valid_lifetime;
        plife_q <= ra_preferred_lifetime;
        pvalid_q <= ra_options_ok;
      end
    end
  end

  // ----------------------------------------
  // wide address store
  // ----------------------------------------
  // the prefix wins a same-cycle clash; the unreachable flag still sets
  wire mem_we = ra_take || evt_ipv6_unreach;
  wire mem_waddr = ra_take ? `EFTS_MEM_PADDR : `EFTS_MEM_IPV6_PORT_UNREACHABLE_FLAG;
  wire efts_wide_t mem_wdata = ra_take ? ra_prefix_address : unreach6_addr;
  wire hit_u6addr = (host_addr & `EFTS_MASK16) == `EFTS_IPV6_PORT_UNREACHABLE_FLAG_ADDR_BASE;
  wire mem_raddr = hit_u6addr ? `EFTS_MEM_IPV6_PORT_UNREACHABLE_FLAG : `EFTS_MEM_PADDR;
  efts_wide_t mem_rdata;
  efts_wide_mem u_mem (
    .mclk(mclk),
    .resetn(resetn),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(mem_raddr),
    .rdata_q(mem_rdata)
  );

  // ----------------------------------------
  // read path
  // ----------------------------------------
  efts_addr_t raddr_q;
  logic rd_q;
  logic rvalid_q;
  efts_byte_t rdata_q;
  wire efts_addr_t a = raddr_q;
  wire r_mem = ((a & `EFTS_MASK16) == `EFTS_PADDR_BASE) || ((a & `EFTS_MASK16) == `EFTS_IPV6_PORT_UNREACHABLE_FLAG_ADDR_BASE);
  wire r_tick = (a & `EFTS_MASK2) == `EFTS_TICK_ADDR;
  wire r_u6p = (a & `EFTS_MASK2) == `EFTS_IPV6_PORT_UNREACHABLE_FLAG_PORT_BASE;
  wire r_u4a = (a & `EFTS_MASK4) == `EFTS_IPV4_PORT_UNREACHABLE_FLAG_ADDR_BASE;
  wire r_u4p = (a & `EFTS_MASK2) == `EFTS_IPV4_PORT_UNREACHABLE_FLAG_PORT_BASE;
  wire r_vl = (a & `EFTS_MASK4) == `EFTS_VLIFE_BASE;
  wire r_pl = (a & `EFTS_MASK4) == `EFTS_PLIFE_BASE;
  wire [6:0] sel16 = {~a[3:0], 3'b000};
  wire [4:0] sel4 = {~a[1:0], 3'b000};
  wire [3:0] sel2 = {~a[0], 3'b000};
  // reserved bits and unmapped addresses read zero; write-only regs read zero
  wire efts_byte_t rmux =
    (a == `EFTS_SYSCFG1_ADDR) ? {ien_q, 6'b000000, core_clock_select_q} :
    r_tick ? tick_q[sel2 +: 8] :
    (a == `EFTS_GFLAG_ADDR) ? gflag_q :
    (a == `EFTS_SUMMARY_ADDR) ? summary_q :
    (a == `EFTS_SLFLAG_ADDR) ? slflag_q :
    (a == `EFTS_GMASK_ADDR) ? gmask_q :
    (a == `EFTS_SMASK_ADDR) ? smask_q :
    (a == `EFTS_SLMASK_ADDR) ? slmask_q :
    r_mem ? mem_rdata[sel16 +: 8] :
    r_u6p ? u6port_q[sel2 +: 8] :
    r_u4a ? u4addr_q[sel4 +: 8] :
    r_u4p ? u4port_q[sel2 +: 8] :
    (a == `EFTS_PLEN_ADDR) ? plen_q :
    (a == `EFTS_PFLAG_ADDR) ? pflag_q :
    (a == `EFTS_PVALID_ADDR) ? {7'b0000000, pvalid_q} :
    r_vl ? vlife_q[sel4 +: 8] :
    r_pl ? plife_q[sel4 +: 8] :
    `EFTS_ZERO8;
  // stage one waits for the store, stage two picks the byte
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      raddr_q <= `EFTS_ZERO16;
      rd_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= `EFTS_ZERO8;
    end else begin
      rd_q <= host_rd;
      if (host_rd) begin
        raddr_q <= host_addr;
      end
      rvalid_q <= rd_q;
      if (rd_q) begin
        rdata_q <= rmux;
      end
    end
  end
  assign host_rdata = rdata_q;
  assign host_rvalid = rvalid_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence s_gclear(int b);
    wr_gclr && host_wdata[b] && !gset[b];
  endsequence
  sequence s_slclear(int b);
    wr_slclr && host_wdata[b] && !socketless_events[b];
  endsequence

  AST_IRQ_OFF: assert property (!ien_q |=> irq_out_low)
    else $error("irq pin low while interrupts disabled");
  AST_IRQ_ON: assert property (ien_q && |(gflag_q & gmask_q) |=> !irq_out_low)
    else $error("irq pin high with masked flag pending");
  AST_MASK_OFF: assert property (ien_q && gmask_q == 8'h00 && summary_q == 8'h00 && slflag_q == 8'h00
    |=> irq_out_low)
    else $error("irq pin low with everything masked");
  AST_CORE_CLOCK_SELECT_LOCK: assert property (chip_config_lock |=> $stable(core_clock_select))
    else $error("clock select changed while locked");
  AST_TICK_STEP: assert property (tick_en && !wr_tclr |=> tick_q == $past(tick_q) + 16'h0001)
    else $error("tick counter missed its step");
  AST_TICK_HOLD: assert property (!tick_en && !wr_tclr |=> $stable(tick_q))
    else $error("tick counter moved between ticks");
  AST_TICK_CLR: assert property (wr_tclr |=> tick_q == 16'h0000 ##1 tick_q == 16'h0000)
    else $error("tick counter not cleared");
  AST_WOL: assert property (evt_wol |=> gflag_q[7])
    else $error("magic packet flag not set");
  AST_IPV6_PORT_UNREACHABLE_FLAG: assert property (evt_ipv6_unreach |=> gflag_q[4] && u6port_q == $past(unreach6_port))
    else $error("ipv6 unreachable not recorded");
  AST_CONF: assert property (evt_ipv4_conflict |=> gflag_q[2])
    else $error("ipv4 conflict flag not set");
  AST_IPV4_PORT_UNREACHABLE_FLAG: assert property (evt_ipv4_unreach |=> gflag_q[1] && u4addr_q == $past(unreach4_addr))
    else $error("ipv4 unreachable not recorded");
  AST_PPPOE_TERMINATED_FLAG: assert property (evt_pppoe_term |=> gflag_q[0])
    else $error("pppoe termination flag not set");
  AST_SUMMARY: assert property (summary_q[3] == $past(|socket_n_flags[31:24]))
    else $error("socket summary bit disagrees with flags");
  AST_SL_SOCKETLESS_TIMEOUT_FLAG: assert property (socketless_events[7] |=> slflag_q[7])
    else $error("socketless timeout flag not set");
  AST_SL_RA: assert property (socketless_events[0] |=> slflag_q[0])
    else $error("unsolicited advertisement flag not set");
  AST_GCLEAR: assert property (s_gclear(2) |=> !gflag_q[2])
    else $error("global flag not cleared by write one");
  AST_SLCLEAR: assert property (s_slclear(6) |=> !slflag_q[6])
    else $error("socketless flag not cleared by write one");
  AST_STICKY: assert property (gflag_q[1] && !(wr_gclr && host_wdata[1]) |=> gflag_q[1])
    else $error("global flag dropped without a clear");
  AST_PREFIX: assert property (ra_take |=> plen_q == $past(ra_prefix_length)
    && pvalid_q == $past(ra_options_ok))
    else $error("prefix values not latched");
  AST_RSVD: assert property (gflag_q[6:5] == 2'b00 && gflag_q[3] == 1'b0 && gmask_q[3] == 1'b0)
    else $error("reserved flag bits set");
endmodule

/* verif/efts_host_model.sv */
// Purpose: host processor model on the byte-wide register port
// Assumes: strobes change on the falling edge of mclk
// Notes: released address and data lines carry the inverse of the last value
`timescale 1ns/1ns
module efts_host_model
  import efts_pkg::*;
(
  input wire logic mclk,
  output efts_addr_t host_addr,
  output logic host_wr,
  output logic host_rd,
  output efts_byte_t host_wdata,
  input wire efts_byte_t host_rdata,
  input wire logic host_rvalid
);
  // ----------------------------------------
  // idle lines
  // ----------------------------------------
  initial begin
    host_addr = 16'h0000;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_wdata = 8'h00;
  end

  // ----------------------------------------
  // bus cycles
  // ----------------------------------------
  // one-cycle write strobe; lines scrambled after release so stale data never looks valid
  task automatic wr(input efts_addr_t a, input efts_byte_t d);
    @(negedge mclk);
    host_addr = a;
    host_wdata = d;
    host_wr = 1'b1;
    @(negedge mclk);
    host_wr = 1'b0;
    host_addr = ~a;
    host_wdata = ~d;
  endtask

  // bounded wait for the valid pulse; a missing answer leaves unknown data
  task automatic rd(input efts_addr_t a, output efts_byte_t d);
    d = 8'hxx;
    @(negedge mclk);
    host_addr = a;
    host_rd = 1'b1;
    @(negedge mclk);
    host_rd = 1'b0;
    host_addr = ~a;
    for (int n = 0; n < 4; n++) begin
      @(negedge mclk);
      if (host_rvalid === 1'b1) begin
        d = host_rdata;
        break;
      end
    end
  endtask
endmodule

/* verif/efts_event_block_tb.sv */
// Purpose: self-checking bench of the event flag, tick and clock select block
// Assumes: inputs change on the falling edge of a 10 MHz mclk
// Notes: expected values come from the register map, never from the design
`timescale 1ns/1ns
`include "efts_defs.svh"
module efts_event_block_tb
  import efts_pkg::*;
;
  logic mclk, resetn, lock, wol, u6, conf4, u4, pppoe_terminated_flag, opt_ok, hwr, hrd, rvalid, irq, csel;
  efts_addr_t haddr;
  efts_byte_t hwdata, rdata, sl_ev, plen, pflg;
  logic [15:0] u6port;
  logic [31:0] u4addr;
  logic [63:0] sock;
  int fail_count = 0;
  int checks_done = 0;
  int gb[5] = '{7, 4, 2, 1, 0};

  efts_event_block uut (.mclk(mclk), .resetn(resetn), .host_addr(haddr), .host_wr(hwr), .host_rd(hrd),
    .host_wdata(hwdata), .host_rdata(rdata), .host_rvalid(rvalid), .chip_config_lock(lock),
    .evt_wol(wol), .evt_ipv6_unreach(u6), .unreach6_addr(128'hfe80_0000_0000_0000_0000_0000_0000_0001),
    .unreach6_port(u6port), .evt_ipv4_conflict(conf4), .evt_ipv4_unreach(u4),
    .unreach4_addr(u4addr), .unreach4_port(16'h1f90), .evt_pppoe_term(pppoe_terminated_flag),
    .socket_n_flags(sock), .socketless_events(sl_ev), .ra_prefix_length(plen), .ra_prefix_flags(pflg),
    .ra_valid_lifetime(32'h0009_3a80), .ra_preferred_lifetime(32'h0009_3a7f),
    .ra_prefix_address(128'h2001_0db8_0000_0000_0000_0000_0000_0000), .ra_options_ok(opt_ok),
    .irq_out_low(irq), .core_clock_select(csel));

  efts_host_model host (.mclk(mclk), .host_addr(haddr), .host_wr(hwr), .host_rd(hrd), .host_wdata(hwdata),
    .host_rdata(rdata), .host_rvalid(rvalid));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rc(input efts_addr_t a, input efts_byte_t e);
    efts_byte_t d;
    host.rd(a, d);
    chk($sformatf("reg %h", a), d, e);
  endtask

  // one-cycle event pulse on the selected global source
  task automatic fire(input int b);
    @(negedge mclk);
    case (b)
      7: wol = 1'b1;
      4: u6 = 1'b1;
      2: conf4 = 1'b1;
      1: u4 = 1'b1;
      default: pppoe_terminated_flag = 1'b1;
    endcase
    @(negedge mclk);
    {wol, u6, conf4, u4, pppoe_terminated_flag} = 5'h00;
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // clock and watchdog
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // all tests need about 2800 cycles; seven times that means a hang
  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    complete_run();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    {resetn, lock, wol, u6, conf4, u4, pppoe_terminated_flag, opt_ok} = 8'h00;
    sl_ev = 8'h00;
    plen = 8'h00;
    {u6port, u4addr, pflg} = {16'hc0de, 32'hc0a8_0107, 8'hc0};
    sock = 64'h0;
    repeat (12) @(negedge mclk);
    resetn = 1'b1;
    chk("irq", {7'h00, irq}, 8'h01);
    rc(`EFTS_SYSCFG1_ADDR, `EFTS_SYSCFG1_RST);
    rc(`EFTS_GFLAG_ADDR, 8'h00);
    rc(`EFTS_SLFLAG_ADDR, 8'h00);
    rc(`EFTS_TICK_ADDR, 8'h00);
    rc(`EFTS_TICK_CLR_ADDR, 8'h00);
    $display("test reset done");
    // clock select: reserved bits dropped, select frozen under lock
    host.wr(`EFTS_SYSCFG1_ADDR, 8'hff);
    rc(`EFTS_SYSCFG1_ADDR, 8'h81);
    chk("core_clock_select", {7'h00, csel}, 8'h01);
    lock = 1'b1;
    host.wr(`EFTS_SYSCFG1_ADDR, 8'h00);
    rc(`EFTS_SYSCFG1_ADDR, 8'h01);
    lock = 1'b0;
    host.wr(`EFTS_SYSCFG1_ADDR, 8'h80);
    rc(`EFTS_SYSCFG1_ADDR, 8'h80);
    chk("core_clock_select", {7'h00, csel}, 8'h00);
    $display("test clock select done");
    // global events, sticky until a write of one clears them
    host.wr(`EFTS_GMASK_ADDR, 8'h97);
    foreach (gb[i]) begin
      fire(gb[i]);
      @(negedge mclk);
      chk("irq", {7'h00, irq}, 8'h00);
      rc(`EFTS_GFLAG_ADDR, 8'h01 << gb[i]);
      host.wr(`EFTS_GCLR_ADDR, ~(8'h01 << gb[i]));
      rc(`EFTS_GFLAG_ADDR, 8'h01 << gb[i]);
      host.wr(`EFTS_GCLR_ADDR, 8'h01 << gb[i]);
      rc(`EFTS_GFLAG_ADDR, 8'h00);
      chk("irq", {7'h00, irq}, 8'h01);
    end
    // inputs move on; the latched copies must keep the event-time values
    {u6port, u4addr} = 48'h0;
    rc(`EFTS_IPV6_PORT_UNREACHABLE_FLAG_ADDR_BASE, 8'hfe);
    rc(`EFTS_IPV6_PORT_UNREACHABLE_FLAG_PORT_BASE + 16'h0001, 8'hde);
    rc(`EFTS_IPV4_PORT_UNREACHABLE_FLAG_ADDR_BASE + 16'h0003, 8'h07);
    rc(`EFTS_IPV4_PORT_UNREACHABLE_FLAG_PORT_BASE, 8'h1f);
    // enable low holds the pin high, mask low too
    host.wr(`EFTS_SYSCFG1_ADDR, 8'h00);
    fire(7);
    repeat (4) @(negedge mclk);
    chk("irq", {7'h00, irq}, 8'h01);
    host.wr(`EFTS_SYSCFG1_ADDR, 8'h80);
    repeat (2) @(negedge mclk);
    chk("irq", {7'h00, irq}, 8'h00);
    host.wr(`EFTS_GMASK_ADDR, 8'h00);
    repeat (2) @(negedge mclk);
    chk("irq", {7'h00, irq}, 8'h01);
    host.wr(`EFTS_GCLR_ADDR, 8'h80);
    $display("test global events done");
    // socket summary follows nonzero flag bytes
    sock = 64'h0001_0000_1000_0000;
    rc(`EFTS_SUMMARY_ADDR, 8'h48);
    sock = 64'h8000_0000_0000_0000;
    rc(`EFTS_SUMMARY_ADDR, 8'h80);
    // socket mask passes only its own bits to the pin
    host.wr(`EFTS_SMASK_ADDR, 8'h01);
    repeat (2) @(negedge mclk);
    chk("irq", {7'h00, irq}, 8'h01);
    sock = 64'h0000_0000_0000_0004;
    repeat (3) @(negedge mclk);
    chk("irq", {7'h00, irq}, 8'h00);
    sock = 64'h0;
    rc(`EFTS_SUMMARY_ADDR, 8'h00);
    chk("irq", {7'h00, irq}, 8'h01);
    $display("test socket summary done");
    // socketless flags; only the two advertisement bits latch prefix data
    for (int b = 0; b < 8; b++) begin
      opt_ok = (b == 1);
      plen = 8'h40 + 8'(b);
      pflg = 8'hc0 + 8'(b);
      @(negedge mclk);
      sl_ev = 8'h01 << b;
      @(negedge mclk);
      sl_ev = 8'h00;
      rc(`EFTS_SLFLAG_ADDR, 8'h01 << b);
      host.wr(`EFTS_SLCLR_ADDR, 8'h01 << b);
      rc(`EFTS_SLFLAG_ADDR, 8'h00);
      if (b < 2) begin
        rc(`EFTS_PVALID_ADDR, 8'(b));
        rc(`EFTS_PLEN_ADDR, 8'h40 + 8'(b));
      end
    end
    rc(`EFTS_PLEN_ADDR, 8'h41);
    rc(`EFTS_PFLAG_ADDR, 8'hc1);
    rc(`EFTS_VLIFE_BASE + 16'h0003, 8'h80);
    rc(`EFTS_PLIFE_BASE + 16'h0003, 8'h7f);
    rc(`EFTS_PADDR_BASE, 8'h20);
    // socketless mask routes the timeout flag onto the pin
    host.wr(`EFTS_SLMASK_ADDR, 8'h80);
    sl_ev = 8'h80;
    @(negedge mclk);
    sl_ev = 8'h00;
    repeat (2) @(negedge mclk);
    chk("irq", {7'h00, irq}, 8'h00);
    host.wr(`EFTS_SLCLR_ADDR, 8'h80);
    rc(`EFTS_SLMASK_ADDR, 8'h80);
    chk("irq", {7'h00, irq}, 8'h01);
    $display("test socketless events done");
    // tick: two increments in 2500 cycles after a clear
    host.wr(`EFTS_TICK_CLR_ADDR, 8'h5a);
    repeat (2500) @(negedge mclk);
    rc(`EFTS_TICK_ADDR + 16'h0001, 8'h02);
    rc(`EFTS_TICK_ADDR, 8'h00);
    host.wr(`EFTS_TICK_CLR_ADDR, 8'h00);
    rc(`EFTS_TICK_ADDR + 16'h0001, 8'h00);
    $display("test tick done");
    complete_run();
  end
endmodule
